// ===== mpct_pkg.sv
// Purpose: shared constants and types of the capture/compare timer
// Assumes: one 25 MHz clock, APB register access
// Notes: offsets are byte addresses, one aligned 32-bit word each
package mpct_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PSC = 8'h04;
	localparam logic [7:0] OFS_ARR = 8'h08;
	localparam logic [7:0] OFS_CNT = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_DMAEN = 8'h18;
	localparam logic [7:0] OFS_CHCFG = 8'h1C;
	localparam logic [7:0] OFS_DT = 8'h20;
	localparam logic [7:0] OFS_CCR0 = 8'h24;
	localparam logic [7:0] OFS_CCR3 = 8'h30;
	localparam int NCH = 4;
	localparam int NPAIR = 3;
	localparam int NEV = 6;
	localparam int EV_UPD = 0;
	localparam int EV_CH0 = 1;
	localparam int EV_TRG = 5;
	localparam int CHCFG_W = 4;
	localparam logic [15:0] PSC_RST = 16'h0000;
	localparam logic [31:0] ARR_RST = 32'h0000FFFF;
	localparam logic [7:0] DT_RST = 8'h00;
	localparam logic [15:0] CHCFG_RST = 16'h0000;
	localparam logic [5:0] EV_RST = 6'h00;
	localparam logic [1:0] CM_UP = 2'h0;
	localparam logic [1:0] CM_DOWN = 2'h1;
	localparam logic [1:0] CM_CENTER = 2'h2;
	localparam logic [1:0] SM_OFF = 2'h0;
	localparam logic [1:0] SM_ENC = 2'h1;
	localparam logic [1:0] SM_EXT = 2'h2;
	localparam logic [1:0] SM_RST = 2'h3;
	localparam logic [1:0] CH_CMP = 2'h0;
	localparam logic [1:0] CH_PWM = 2'h1;
	localparam logic [1:0] CH_CAPR = 2'h2;
	localparam logic [1:0] CH_CAPF = 2'h3;
	typedef struct packed {
		logic hall_sel;
		logic [1:0] slave;
		logic moe;
		logic basic;
		logic freeze;
		logic one_per;
		logic wide;
		logic [1:0] cmode;
		logic en;
	} mpct_ctrl_t;
	localparam int CTRL_W = 11;
	localparam logic [10:0] CTRL_RST = 11'h000;
	typedef struct packed {
		logic en;
		logic [1:0] mode;
	} mpct_chcfg_t;
	typedef enum logic [2:0] {
		DT_OFF = 3'b001,
		DT_MAIN = 3'b010,
		DT_COMP = 3'b100
	} mpct_dtst_t;
endpackage

// ===== mpct_chan.sv
// Purpose: one capture/compare channel
// Assumes: cnt and ccr come from the counter and its compare register
// Notes: capture value itself is stored by the parent
module mpct_chan (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Channel setup and counter view
	input wire mpct_pkg::mpct_chcfg_t cfg,
	input wire logic [31:0] cnt,
	input wire logic [31:0] ccr,
	input wire logic step,
	input wire logic pin_in,
	// Results
	output logic ref_out,
	output logic evt
);
	import mpct_pkg::*;
	logic pin_prev;
	logic hit;

	assign hit = step && cnt == ccr;

	always_ff @(posedge sys_clk) begin
		if (reset)
			pin_prev <= 1'b0;
		else
			pin_prev <= pin_in;
	end

	always_ff @(posedge sys_clk) begin
		if (reset || !cfg.en) begin
			ref_out <= 1'b0;
			evt <= 1'b0;
		end else begin
			case (cfg.mode)
				CH_CMP: begin
					evt <= hit;
					if (hit)
						ref_out <= ~ref_out;
				end
				CH_PWM: begin
					evt <= hit;
					// ccr 0 is fully off, ccr above top fully on
					ref_out <= cnt < ccr;
				end
				CH_CAPR: begin
					evt <= pin_in & ~pin_prev;
					ref_out <= 1'b0;
				end
				default: begin
					evt <= ~pin_in & pin_prev;
					ref_out <= 1'b0;
				end
			endcase
		end
	end

	a_pwm_zero: assert property (@(posedge sys_clk) disable iff (reset)
		(cfg.en && cfg.mode == CH_PWM && ccr == 32'h00000000)
		|=> !ref_out) else $error("pwm not off at zero duty");
	a_pwm_full: assert property (@(posedge sys_clk) disable iff (reset)
		(cfg.en && cfg.mode == CH_PWM && ccr == 32'h00010000 &&
		cnt[31:16] == 16'h0000) |=> ref_out)
		else $error("pwm not on at full duty");
endmodule

// ===== mpct_dtgen.sv
// Purpose: main/complementary output pair with dead-time
// Assumes: dt counts sys_clk cycles
// Notes: at least one dead cycle is always inserted
module mpct_dtgen (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Control
	input wire logic ref_in,
	input wire logic [7:0] dt,
	input wire logic force_off,
	input wire logic en_comp,
	// Pins
	output logic out_p,
	output logic out_n
);
	import mpct_pkg::*;
	mpct_dtst_t state;
	mpct_dtst_t next_state;
	logic [7:0] dcnt;

	always_comb begin
		next_state = state;
		case (state)
			DT_OFF: begin
				if (!force_off && dcnt == 8'h00)
					next_state = ref_in ? DT_MAIN : DT_COMP;
			end
			DT_MAIN: begin
				if (force_off || !ref_in)
					next_state = DT_OFF;
			end
			DT_COMP: begin
				if (force_off || ref_in)
					next_state = DT_OFF;
			end
			default: next_state = DT_OFF;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= DT_OFF;
			dcnt <= 8'h00;
			out_p <= 1'b0;
			out_n <= 1'b0;
		end else begin
			state <= next_state;
			// Both switches stay off while the gap runs out
			if (next_state == DT_OFF && state != DT_OFF)
				dcnt <= dt;
			else if (dcnt != 8'h00)
				dcnt <= dcnt - 8'h01;
			out_p <= next_state == DT_MAIN;
			out_n <= next_state == DT_COMP && en_comp;
		end
	end

	sequence s_dead2;
		(!out_p && !out_n) [*2];
	endsequence

	a_no_overlap: assert property (@(posedge sys_clk) disable iff (reset)
		!(out_p && out_n)) else $error("both switches on");
	a_dead_gap: assert property (@(posedge sys_clk) disable iff (reset)
		(state == DT_MAIN && !ref_in && dt != 8'h00) |=> s_dead2)
		else $error("dead-time gap too short");
endmodule

// ===== mpct_timer.sv
// Purpose: prescaled auto-reload timer, four channels, dead-time pairs
// Assumes: APB slave, inputs synchronous to sys_clk
// Notes: one clock; prescaler gives a one-cycle count enable
//
// Register access over APB and the register addresses were decided locally.

// Contract
// - Counter clock is the input clock divided by any factor 1 to 65536.
// - Prescaler setting is a 16-bit software value.
// - Counter is 16 bits, auto-reloading, counts up, down or up/down.
// - A mode bit widens the counter to 32 bits.
// - Four channels: capture, compare, edge/center PWM, one-period.
// - Three complementary pairs with programmable dead-time.
// - PWM duty reaches fully off and fully on.
// - Without output pairs enabled it acts as a plain timer.
// - Debug halt can freeze the counter and force outputs off.
// - Debug halt can freeze the counter.
// - Trigger in and out link timers for sync or chained counting.
// - Decodes quadrature encoders and one to three hall sensors.
// - The timer raises its own DMA requests.
// - Two-channel use: two channels plus two complementary outputs.
// - Single-channel use: one channel, one complement, or time base.
// - Basic use counts up except in encoder mode; channels are off but the three complements stay on unless forced off.
// - Update event is a converter trigger and DMA source.
module mpct_timer (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Channel and sensor pins
	input wire logic [3:0] cap_in,
	input wire logic enc_a,
	input wire logic enc_b,
	input wire logic [2:0] hall_in,
	output logic [3:0] ch_out,
	output logic [2:0] ch_out_n,
	// Link and debug
	input wire logic link_trig_in,
	input wire logic debug_halt,
	output logic link_trig_out,
	// System events
	output logic irq,
	output logic [5:0] dma_req,
	output logic dac_trig
);
	import mpct_pkg::*;

	mpct_ctrl_t ctrl;
	mpct_ctrl_t ctrl_wd;
	logic [15:0] psc;
	logic [15:0] psc_cnt;
	logic [31:0] arr;
	logic [31:0] cnt;
	logic [31:0] next_cnt;
	logic cdir;
	logic next_cdir;
	logic [5:0] status;
	logic [5:0] next_status;
	logic [5:0] mask;
	logic [5:0] dma_en;
	logic [15:0] chcfg;
	logic [7:0] dt;
	logic [31:0] ccr [NCH];
	logic [31:0] rdata;
	logic unmapped;
	logic wr;
	logic tick;
	logic run;
	logic frz;
	logic step;
	logic trig_reset;
	logic down;
	logic upd;
	logic [31:0] top;
	logic enc_prev;
	logic trig_prev;
	logic enc_edge;
	logic trig_rise;
	logic [5:0] ev;
	logic [NCH-1:0] ch_ref;
	logic [NCH-1:0] ch_evt;
	logic [NCH-1:0] pair_n;
	logic [NCH-1:0] pin;
	logic force_off;
	logic ccr_wr;
	logic [1:0] ccr_idx;

	// Register access
	assign wr = psel && penable && pready && pwrite;
	assign ctrl_wd = mpct_ctrl_t'(pwdata[CTRL_W-1:0]);
	assign ccr_idx = 2'(paddr[3:2] - OFS_CCR0[3:2]);
	assign ccr_wr = paddr >= OFS_CCR0 && paddr <= OFS_CCR3;

	always_comb begin
		rdata = 32'h00000000;
		unmapped = 1'b0;
		case (paddr)
			OFS_CTRL: rdata = {21'h000000, ctrl};
			OFS_PSC: rdata = {16'h0000, psc};
			OFS_ARR: rdata = arr;
			OFS_CNT: rdata = cnt;
			OFS_STAT: rdata = {26'h0000000, status};
			OFS_MASK: rdata = {26'h0000000, mask};
			OFS_DMAEN: rdata = {26'h0000000, dma_en};
			OFS_CHCFG: rdata = {16'h0000, chcfg};
			OFS_DT: rdata = {24'h000000, dt};
			default: begin
				if (ccr_wr && paddr[1:0] == 2'h0)
					rdata = ccr[ccr_idx];
				else
					unmapped = 1'b1;
			end
		endcase
	end

	// One wait-free access phase: data is ready when penable rises
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			prdata <= rdata;
			pslverr <= psel && !penable && unmapped;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			psc <= PSC_RST;
			arr <= ARR_RST;
			mask <= EV_RST;
			dma_en <= EV_RST;
			chcfg <= CHCFG_RST;
			dt <= DT_RST;
		end else if (wr) begin
			case (paddr)
				OFS_PSC: psc <= pwdata[15:0];
				OFS_ARR: arr <= pwdata;
				OFS_MASK: mask <= pwdata[5:0];
				OFS_DMAEN: dma_en <= pwdata[5:0];
				OFS_CHCFG: chcfg <= pwdata[15:0];
				OFS_DT: dt <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// One-period mode stops the counter at its first update
	always_ff @(posedge sys_clk) begin
		if (reset)
			ctrl <= mpct_ctrl_t'(CTRL_RST);
		else if (wr && paddr == OFS_CTRL)
			ctrl <= ctrl_wd;
		else if (upd && ctrl.one_per)
			ctrl.en <= 1'b0;
	end

	// Prescaler: factor is psc + 1
	assign frz = debug_halt && ctrl.freeze;
	assign run = ctrl.en && !frz;
	assign tick = run && psc_cnt == psc;

	always_ff @(posedge sys_clk) begin
		if (reset || !run)
			psc_cnt <= 16'h0000;
		else if (tick)
			psc_cnt <= 16'h0000;
		else
			psc_cnt <= psc_cnt + 16'h0001;
	end

	// Edge detectors for encoder and link trigger
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			enc_prev <= 1'b0;
			trig_prev <= 1'b0;
		end else begin
			enc_prev <= enc_a;
			trig_prev <= link_trig_in;
		end
	end

	assign enc_edge = enc_a ^ enc_prev;
	assign trig_rise = link_trig_in && !trig_prev;
	assign top = ctrl.wide ? arr : {16'h0000, arr[15:0]};

	// Counter clock source and direction
	always_comb begin
		step = 1'b0;
		trig_reset = 1'b0;
		down = !ctrl.basic && ctrl.cmode == CM_DOWN;
		case (ctrl.slave)
			SM_ENC: begin
				step = run && enc_edge;
				down = enc_a ^ enc_b ^ 1'b1;
			end
			SM_EXT: step = run && trig_rise;
			SM_RST: begin
				step = run && tick;
				trig_reset = run && trig_rise;
			end
			default: step = run && tick;
		endcase
	end

	// Reload at overflow or underflow, update at each end
	always_comb begin
		next_cnt = cnt;
		next_cdir = cdir;
		upd = 1'b0;
		if (trig_reset) begin
			next_cnt = 32'h00000000;
			upd = 1'b1;
		end else if (step) begin
			if (ctrl.cmode == CM_CENTER && !ctrl.basic &&
				ctrl.slave != SM_ENC) begin
				if (!cdir && cnt >= top) begin
					next_cnt = cnt - 32'h00000001;
					next_cdir = 1'b1;
					upd = 1'b1;
				end else if (cdir && cnt == 32'h00000000) begin
					next_cnt = 32'h00000001;
					next_cdir = 1'b0;
					upd = 1'b1;
				end else if (cdir)
					next_cnt = cnt - 32'h00000001;
				else
					next_cnt = cnt + 32'h00000001;
			end else if (down) begin
				if (cnt == 32'h00000000) begin
					next_cnt = top;
					upd = 1'b1;
				end else
					next_cnt = cnt - 32'h00000001;
			end else if (cnt >= top) begin
				next_cnt = 32'h00000000;
				upd = 1'b1;
			end else
				next_cnt = cnt + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt <= 32'h00000000;
			cdir <= 1'b0;
		end else if (wr && paddr == OFS_CNT) begin
			cnt <= ctrl.wide ? pwdata : {16'h0000, pwdata[15:0]};
			cdir <= 1'b0;
		end else if (wr && paddr == OFS_CTRL && !ctrl_wd.wide) begin
			cnt <= {16'h0000, next_cnt[15:0]};
			cdir <= next_cdir;
		end else begin
			cnt <= next_cnt;
			cdir <= next_cdir;
		end
	end

	// Hall sensors share channel 0 through their parity
	assign pin = {cap_in[3:1], ctrl.hall_sel ? ^hall_in : cap_in[0]};
	// Outputs idle only with moe clear or when frozen; off and basic channels still drive their complements
	assign force_off = frz || !ctrl.moe;

	genvar i;
	generate
		for (i = 0; i < NCH; i++) begin : g_ch
			mpct_chcfg_t cfg_i;
			assign cfg_i = mpct_chcfg_t'({chcfg[CHCFG_W*i+2] && !ctrl.basic,
				chcfg[CHCFG_W*i +: 2]});
			mpct_chan u_chan (
				.sys_clk(sys_clk),
				.reset(reset),
				.cfg(cfg_i),
				.cnt(cnt),
				.ccr(ccr[i]),
				.step(step),
				.pin_in(pin[i]),
				.ref_out(ch_ref[i]),
				.evt(ch_evt[i])
			);
			// A capture beats a bus write in the same cycle
			always_ff @(posedge sys_clk) begin
				if (reset)
					ccr[i] <= 32'h00000000;
				else if (ch_evt[i] && cfg_i.mode[1])
					ccr[i] <= cnt;
				else if (wr && ccr_wr && ccr_idx == 2'(i))
					ccr[i] <= pwdata;
			end
			mpct_dtgen u_dt (
				.sys_clk(sys_clk),
				.reset(reset),
				.ref_in(ch_ref[i]),
				.dt(dt),
				.force_off(force_off),
				.en_comp(i < NPAIR),
				.out_p(ch_out[i]),
				.out_n(pair_n[i])
			);
		end
	endgenerate

	assign ch_out_n = pair_n[NPAIR-1:0];
	// Sticky flags: a new event wins over a clear in the same cycle
	assign ev = {trig_rise, ch_evt, upd};

	always_comb begin
		next_status = status;
		if (wr && paddr == OFS_STAT)
			next_status = status & ~pwdata[5:0];
		next_status = next_status | ev;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			status <= EV_RST;
			irq <= 1'b0;
			dma_req <= EV_RST;
			dac_trig <= 1'b0;
			link_trig_out <= 1'b0;
		end else begin
			status <= next_status;
			irq <= |(next_status & mask);
			dma_req <= ev & dma_en;
			dac_trig <= upd;
			link_trig_out <= upd;
		end
	end

	a_tick_spacing: assert property (@(posedge sys_clk) disable iff (reset)
		(tick && psc == 16'h0002) ##1 (run && psc == 16'h0002) [*3] |->
		tick && !$past(tick) && !$past(tick, 2))
		else $error("prescaler period wrong");
	a_narrow_cnt: assert property (@(posedge sys_clk) disable iff (reset)
		!ctrl.wide |-> cnt[31:16] == 16'h0000)
		else $error("16-bit counter overflowed its width");
	a_wide_count: assert property (@(posedge sys_clk) disable iff (reset)
		(ctrl.wide && !down && ctrl.cmode == CM_UP && step && !wr &&
		!trig_reset && cnt < top) |=> cnt == $past(cnt) + 32'h00000001)
		else $error("32-bit count step wrong");
	a_up_reload: assert property (@(posedge sys_clk) disable iff (reset)
		(step && !down && ctrl.cmode == CM_UP && cnt >= top && !wr &&
		!trig_reset) |=> (cnt == 32'h00000000 && dac_trig))
		else $error("overflow did not reload");
	a_freeze_cnt: assert property (@(posedge sys_clk) disable iff (reset)
		(frz && !wr) |=> cnt == $past(cnt))
		else $error("counter moved while frozen");
	a_freeze_out: assert property (@(posedge sys_clk) disable iff (reset)
		frz |=> (ch_out == 4'h0 && ch_out_n == 3'h0))
		else $error("outputs active while frozen");
	a_capture_val: assert property (@(posedge sys_clk) disable iff (reset)
		(ch_evt[0] && chcfg[1]) |=> ccr[0] == $past(cnt))
		else $error("capture value lost");
	a_irq_level: assert property (@(posedge sys_clk) disable iff (reset)
		$stable(mask) |-> irq == |(status & mask))
		else $error("interrupt level mismatch");
	a_dma_upd: assert property (@(posedge sys_clk) disable iff (reset)
		(upd && dma_en[EV_UPD]) |=> dma_req[EV_UPD])
		else $error("update did not request dma");
endmodule

// ===== mpct_partner.sv
// Purpose: encoder, hall sensors, capture source and three power switch pairs
// Assumes: lines change by non-blocking assignment after rising edges
// Notes: overlap counts cycles in which a pair would conduct together
module mpct_partner (
	// Clock
	input wire logic sys_clk,
	// Switch gates driven by the timer
	input wire logic [3:0] ch_out,
	input wire logic [2:0] ch_out_n,
	// Sensor lines into the timer
	output logic [3:0] cap_in,
	output logic enc_a,
	output logic enc_b,
	output logic [2:0] hall_in,
	// Observations
	output logic [7:0] overlap,
	output logic comp_seen
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cap_in = 4'h0;
		enc_a = 1'b0;
		enc_b = 1'b0;
		hall_in = 3'h0;
		overlap = 8'h00;
		comp_seen = 1'b0;
	end
	// Both switches of a leg on at once would short the supply
	always @(posedge sys_clk) begin
		if ((ch_out[2:0] & ch_out_n) != 3'h0)
			overlap <= overlap + 8'h01;
		if (ch_out_n[0] === 1'b1)
			comp_seen <= 1'b1;
	end
	// Forward quadrature step: phase b follows a, then a moves on
	task automatic enc_step(input int n);
		repeat (n) begin
			@(posedge sys_clk) enc_b <= enc_a;
			@(posedge sys_clk) enc_a <= ~enc_a;
			repeat (2) @(posedge sys_clk);
		end
	endtask
	task automatic cap_pulse(input int ch);
		@(posedge sys_clk) cap_in[ch] <= 1'b1;
		repeat (3) @(posedge sys_clk);
		cap_in[ch] <= 1'b0;
	endtask
	task automatic hall_set(input logic [2:0] v);
		@(posedge sys_clk) hall_in <= v;
	endtask
endmodule

// ===== mpct_timer_tb.sv
// Purpose: self-checking bench for the capture/compare timer
// Assumes: zero-wait APB slave, 25 MHz clock
// Notes: periods are measured between dac_trig pulses
`define CHK(nm, ex, gt) begin \
	tests_run++; \
	if ((gt) !== (ex)) begin \
		n_fail++; \
		$display("mismatch %s exp %0h got %0h", nm, ex, gt); \
	end \
end
module mpct_timer_tb
	import mpct_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, overlap;
	logic [31:0] pwdata, prdata, d, d2;
	logic [3:0] cap_in, ch_out;
	logic [2:0] hall_in, ch_out_n;
	logic enc_a, enc_b, link_trig_in, debug_halt, link_trig_out;
	logic irq, dac_trig, comp_seen;
	logic [5:0] dma_req;
	int n_fail, tests_run, n;
	mpct_timer u_mpct_timer (.sys_clk(sys_clk), .reset(reset),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cap_in(cap_in), .enc_a(enc_a), .enc_b(enc_b),
		.hall_in(hall_in), .ch_out(ch_out), .ch_out_n(ch_out_n),
		.link_trig_in(link_trig_in), .debug_halt(debug_halt),
		.link_trig_out(link_trig_out), .irq(irq), .dma_req(dma_req),
		.dac_trig(dac_trig));
	mpct_partner u_mpct_partner (.sys_clk(sys_clk), .ch_out(ch_out),
		.ch_out_n(ch_out_n), .cap_in(cap_in), .enc_a(enc_a),
		.enc_b(enc_b), .hall_in(hall_in), .overlap(overlap),
		.comp_seen(comp_seen));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Wait as long as the slave needs; only the watchdog ends it
		do @(posedge sys_clk); while (pready !== 1'b1);
		d = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		apb(a, 1'b1, v);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(a, 1'b0, 32'h00000000);
	endtask
	// The first update may come early; only the next interval is timed
	task automatic period(input int ex, input logic dm);
		do @(posedge sys_clk); while (dac_trig !== 1'b1);
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (dac_trig !== 1'b1 && n < 300);
		`CHK("period", ex, n)
		`CHK("link_out", 1'b1, link_trig_out)
		`CHK("dma_upd", dm, dma_req[0])
	endtask
	task automatic give_verdict();
		if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		#800000;
		n_fail++;
		give_verdict();
	end
	initial begin
		reset = 1'b1;
		{psel, penable, pwrite, link_trig_in, debug_halt} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		n_fail = 0;
		tests_run = 0;
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		rd(OFS_ARR);
		`CHK("arr_rst", ARR_RST, d)
		rd(8'h40);
		`CHK("unmapped", 33'h100000000, {err, d})
		wr(OFS_PSC, 32'hFFFFFFFF);
		rd(OFS_PSC);
		`CHK("psc_width", 32'h0000FFFF, d)
		wr(OFS_PSC, 32'h00000000);
		wr(OFS_ARR, 32'h00000002);
		wr(OFS_CTRL, 32'h00000001);
		period(3, 1'b0);
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_PSC, 32'h00000002);
		wr(OFS_ARR, 32'h00000003);
		wr(OFS_CTRL, 32'h00000001);
		period(12, 1'b0);
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_PSC, 32'h00000000);
		wr(OFS_ARR, 32'h00010002);
		rd(OFS_ARR);
		`CHK("arr32", 32'h00010002, d)
		wr(OFS_CTRL, 32'h00000001);
		period(3, 1'b0);
		wr(OFS_CTRL, 32'h00000008);
		wr(OFS_CNT, 32'h0000FFFE);
		wr(OFS_CTRL, 32'h00000009);
		wr(OFS_CTRL, 32'h00000008);
		rd(OFS_CNT);
		`CHK("cnt32", 32'h00010001, d)
		wr(OFS_DMAEN, 32'h00000001);
		wr(OFS_CTRL, 32'h00000003);
		period(3, 1'b1);
		wr(OFS_CTRL, 32'h00000005);
		period(2, 1'b1);
		wr(OFS_CTRL, 32'h00000000);
		rd(OFS_STAT);
		`CHK("upd_flag", 2'b01, {irq, d[0]})
		wr(OFS_MASK, 32'h00000001);
		repeat (2) @(posedge sys_clk);
		`CHK("irq_on", 1'b1, irq)
		wr(OFS_STAT, 32'h00000001);
		repeat (2) @(posedge sys_clk);
		rd(OFS_STAT);
		`CHK("irq_clr", 2'b00, {irq, d[0]})
		wr(OFS_CNT, 32'h00000000);
		wr(OFS_CTRL, 32'h00000011);
		repeat (10) @(posedge sys_clk);
		rd(OFS_CTRL);
		`CHK("one_period", 32'h00000010, d)
		wr(OFS_CHCFG, 32'h00000005);
		wr(OFS_CCR0, 32'h00010000);
		wr(OFS_CTRL, 32'h000000A1);
		repeat (10) @(posedge sys_clk);
		`CHK("full_on", 2'b10, {ch_out[0], ch_out_n[0]})
		wr(OFS_CCR0, 32'h00000000);
		repeat (10) @(posedge sys_clk);
		`CHK("full_off", 1'b0, ch_out[0])
		wr(OFS_CCR0, 32'h00000001);
		wr(OFS_DT, 32'h00000003);
		repeat (60) @(posedge sys_clk);
		`CHK("comp_seen", 1'b1, comp_seen)
		`CHK("overlap", 8'h00, overlap)
		debug_halt <= 1'b1;
		repeat (5) @(posedge sys_clk);
		`CHK("halt_off", 7'h00, {ch_out, ch_out_n})
		rd(OFS_CNT);
		d2 = d;
		repeat (8) @(posedge sys_clk);
		rd(OFS_CNT);
		`CHK("frozen", d2, d)
		debug_halt <= 1'b0;
		wr(OFS_CCR0, 32'h00000010);
		wr(OFS_CTRL, 32'h000000C1);
		repeat (10) @(posedge sys_clk);
		`CHK("basic_off", 1'b0, ch_out[0])
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_CHCFG, 32'h00000076);
		wr(OFS_STAT, 32'h0000003F);
		wr(OFS_CTRL, 32'h00000401);
		u_mpct_partner.cap_pulse(1);
		u_mpct_partner.hall_set(3'b001);
		repeat (4) @(posedge sys_clk);
		rd(OFS_STAT);
		`CHK("cap_flags", 2'b11, d[2:1])
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_ARR, 32'h0000FFFF);
		wr(OFS_CNT, 32'h00000000);
		wr(OFS_CTRL, 32'h00000101);
		u_mpct_partner.enc_step(5);
		repeat (3) @(posedge sys_clk);
		rd(OFS_CNT);
		`CHK("enc_cnt", 32'h00000005, d)
		wr(OFS_CTRL, 32'h00000000);
		wr(OFS_CNT, 32'h00000000);
		wr(OFS_STAT, 32'h0000003F);
		wr(OFS_CTRL, 32'h00000201);
		repeat (3) begin
			@(posedge sys_clk) link_trig_in <= 1'b1;
			@(posedge sys_clk) link_trig_in <= 1'b0;
		end
		repeat (3) @(posedge sys_clk);
		rd(OFS_CNT);
		`CHK("link_cnt", 32'h00000003, d)
		rd(OFS_STAT);
		`CHK("link_flag", 1'b1, d[5])
		give_verdict();
	end
endmodule
